// File: current_pin_model.sv
/* Model of the analogue output pin: signed current in microamps.
   Assumes a registered drive word from the control logic. */
`timescale 1ns/1ps
module current_pin_model
    import current_ref_pkg::*;
(
    input  wire unit_drive_t drive_i,
    output int               current_ua_o
);
    // ==========================================
    // Output current
    // ==========================================
    int step_ua;
    assign step_ua = drive_i.high_range ? STEP_HIGH_UA : STEP_LOW_UA;
    // Disabled unit draws nothing, so fine weight is ignored too
    assign current_ua_o = !drive_i.enable ? 0 :
        (drive_i.sink ? -1 : 1) * step_ua * int'(drive_i.total_steps);
endmodule

// File: current_ref_control.sv
/*
 * Control logic of the programmable current unit: two byte registers on
 * the special-function port, and the drive word sent to the analogue cell.
 * Assumes the compare outputs come from logic on the same clock, and that
 * the bus master holds read and write strobes for one cycle per access.
 */
// Overview of operation
// (R1) Control bit 7: 0 source, 1 sink
// (R2) Control bit 6 picks 1 or 8 uA
// (R3) Bits 5:0 are step count magnitude
// (R4) Zero step count disables, low power
// (R5) Control register at page 0, 0xd6
// (R6) Config bit 7 enables fine tuning
// (R7) Config bits 2:0 pick compare channel
// (R8) Selected compare gates two-LSB current source
// (R9) Full-duty gate equals adding 10b
// (R10) Config bits 6:3 read zero, unwritable
// (R11) Config register at 0xb9, any page
// (R12) Both registers reset to zero
// (R13) Reserved source code holds gate low
`timescale 1ns/1ps

module current_ref_control
    import current_ref_pkg::*;
#(
    parameter int NUM_CHANNELS = 3
) (
    input  wire logic              ref_clk_i,
    input  wire logic              srst_i,
    input  wire logic [7:0]        sfr_addr_i,
    input  wire logic [3:0]        sfr_page_i,
    input  wire logic              sfr_wr_i,
    input  wire logic              sfr_rd_i,
    input  wire logic [7:0]        sfr_wdata_i,
    output logic      [7:0]        sfr_rdata_o,
    input  wire logic [NUM_CHANNELS-1:0] counter_compare_output_i,
    output unit_drive_t            unit_drive_o
);

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    if (NUM_CHANNELS != 3) begin : g_bad_channels
        $error("current_ref_control supports exactly three compare channels");
    end

    // ==========================================================
    // Register storage
    // ==========================================================
    logic [7:0]  ctrl_q;
    logic [7:0]  ctrl_d;
    logic [7:0]  cfg_q;
    logic [7:0]  cfg_d;
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;
    unit_drive_t drive_q;
    unit_drive_t drive_d;

    // ==========================================================
    // Address decode
    // ==========================================================
    wire ctrl_hit = (sfr_addr_i == CTRL_ADDR) && (sfr_page_i == CTRL_PAGE); // [R5]
    wire cfg_hit  = (sfr_addr_i == CFG_ADDR);                               // [R11]

    assign ctrl_d = (sfr_wr_i && ctrl_hit) ? sfr_wdata_i : ctrl_q;
    // Unused bits are never stored, so they cannot leak into read data
    assign cfg_d  = (sfr_wr_i && cfg_hit) ? (sfr_wdata_i & CFG_WRITE_MASK) : cfg_q; // [R10]

    assign rdata_d = !sfr_rd_i ? rdata_q :
                     ctrl_hit  ? ctrl_q  :
                     cfg_hit   ? (cfg_q & CFG_WRITE_MASK) :                 // [R10]
                                 UNMAPPED_READ;

    // ==========================================================
    // Drive word decode
    // ==========================================================
    wire [5:0] step_w    = ctrl_q[CTRL_STEP_MSB:0];                         // [R3]
    wire       fine_en_w = cfg_q[CFG_EN_BIT];                               // [R6]
    wire [2:0] src_w     = cfg_q[CFG_SRC_MSB:0];
    // Reserved codes select nothing, so the extra source stays off
    wire       src_ok_w  = (src_w == SRC_CH0) || (src_w == SRC_CH1) ||
                           (src_w == SRC_CH2);                              // [R13]
    wire       cmp_sel_w = counter_compare_output_i[src_w[1:0]];            // [R7]
    wire       gate_w    = fine_en_w && src_ok_w && cmp_sel_w;              // [R8] [R13]

    assign drive_d.enable      = (step_w != STEP_OFF);                      // [R4]
    assign drive_d.sink        = ctrl_q[CTRL_SINK_BIT];                     // [R1]
    assign drive_d.high_range  = ctrl_q[CTRL_RANGE_BIT];                    // [R2]
    assign drive_d.step_count  = step_w;                                    // [R3]
    assign drive_d.fine_on     = gate_w;                                    // [R8]
    // Gate adds a weight of two steps, so 00b plus full duty equals 10b
    assign drive_d.total_steps = {1'b0, step_w} + (gate_w ? FINE_WEIGHT : 7'h00); // [R9]

    // ==========================================================
    // Flip-flops
    // ==========================================================
    // One short block per register, so each reset value is easy to audit
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            ctrl_q <= CTRL_RESET;                                           // [R12]
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            cfg_q <= CFG_RESET;                                             // [R12]
        end else begin
            cfg_q <= cfg_d;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rdata_q <= UNMAPPED_READ;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Registered drive word costs a cycle but keeps glitches off the cell
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            drive_q <= '0;
        end else begin
            drive_q <= drive_d;
        end
    end

    assign sfr_rdata_o  = rdata_q;
    assign unit_drive_o = drive_q;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    AST_SINK_FOLLOWS_WRITE: assert property ( // [R1]
        sfr_wr_i && ctrl_hit |-> ##2 unit_drive_o.sink == $past(sfr_wdata_i[7], 2))
        else $error("Sink bit did not follow control write");

    AST_RANGE_FOLLOWS_WRITE: assert property ( // [R2]
        sfr_wr_i && ctrl_hit |-> ##2 unit_drive_o.high_range == $past(sfr_wdata_i[6], 2))
        else $error("Range bit did not follow control write");

    AST_STEP_FOLLOWS_WRITE: assert property ( // [R3]
        sfr_wr_i && ctrl_hit |-> ##2 unit_drive_o.step_count == $past(sfr_wdata_i[5:0], 2))
        else $error("Step count did not follow control write");

    AST_ZERO_DISABLES: assert property ( // [R4]
        sfr_wr_i && ctrl_hit && sfr_wdata_i[5:0] == 6'h00 |-> ##2 !unit_drive_o.enable)
        else $error("Zero step count left unit enabled");

    AST_CTRL_PAGE_ONLY: assert property ( // [R5]
        sfr_wr_i && sfr_addr_i == CTRL_ADDR && sfr_page_i != CTRL_PAGE |=> $stable(ctrl_q))
        else $error("Control register written on wrong page");

    AST_FINE_OFF_NO_GATE: assert property ( // [R6]
        !cfg_q[CFG_EN_BIT] |=> !unit_drive_o.fine_on)
        else $error("Fine gate active with fine tuning off");

    AST_GATE_TRACKS_CHANNEL: assert property ( // [R7]
        cfg_q[CFG_EN_BIT] && cfg_q[2:0] == SRC_CH1 |=>
            unit_drive_o.fine_on == $past(counter_compare_output_i[1]))
        else $error("Fine gate does not track channel 1");

    AST_WEIGHT_TWO: assert property ( // [R8]
        unit_drive_o.total_steps ==
            {1'b0, unit_drive_o.step_count} + (unit_drive_o.fine_on ? 7'h02 : 7'h00))
        else $error("Extra source weight is not two steps");

    AST_FULL_DUTY_EQUALS_10B: assert property ( // [R9]
        unit_drive_o.fine_on && unit_drive_o.step_count[1:0] == 2'b00 |->
            unit_drive_o.total_steps[1:0] == 2'b10)
        else $error("Full duty does not match 10b");

    AST_CFG_UNUSED_ZERO: assert property ( // [R10]
        sfr_rd_i && cfg_hit && !ctrl_hit |=> sfr_rdata_o[6:3] == 4'h0)
        else $error("Config unused bits read nonzero");

    AST_CFG_ANY_PAGE: assert property ( // [R11]
        sfr_wr_i && cfg_hit |=> cfg_q == (($past(sfr_wdata_i)) & CFG_WRITE_MASK))
        else $error("Config write lost on some page");

    AST_RESET_ZERO: assert property ( // [R12]
        @(posedge ref_clk_i) disable iff (1'b0)
        srst_i |=> ctrl_q == 8'h00 && cfg_q == 8'h00 && unit_drive_o == '0)
        else $error("Registers not zero after reset");

    AST_RESERVED_GATE_LOW: assert property ( // [R13]
        cfg_q[2:0] > SRC_CH2 |=> !unit_drive_o.fine_on)
        else $error("Reserved source code opened the gate");

    // ==========================================================
    // Drive word against the registers
    // ==========================================================
    AST_SINK_FROM_REG: assert property ( // [R1]
        1'b1 |=> unit_drive_o.sink == $past(ctrl_q[CTRL_SINK_BIT]))
        else $error("Sink bit differs from control register");

    AST_RANGE_FROM_REG: assert property ( // [R2]
        1'b1 |=> unit_drive_o.high_range == $past(ctrl_q[CTRL_RANGE_BIT]))
        else $error("Range bit differs from control register");

    AST_STEP_FROM_REG: assert property ( // [R3]
        1'b1 |=> unit_drive_o.step_count == $past(ctrl_q[5:0]))
        else $error("Step count differs from control register");

    AST_PLAIN_TOTAL: assert property ( // [R3]
        !unit_drive_o.fine_on |-> unit_drive_o.total_steps == {1'b0, unit_drive_o.step_count})
        else $error("Total steps differ from step count");

    AST_NONZERO_ENABLES: assert property ( // [R4]
        unit_drive_o.step_count != 6'h00 |-> unit_drive_o.enable)
        else $error("Nonzero step count left unit disabled");

    AST_DISABLED_STEP_ZERO: assert property ( // [R4]
        !unit_drive_o.enable |-> unit_drive_o.step_count == 6'h00)
        else $error("Unit disabled with nonzero step count");

    // Compare inputs share the clock, so one cycle of latency is exact
    AST_FINE_ON_WHEN_ENABLED: assert property ( // [R6]
        cfg_q[CFG_EN_BIT] && cfg_q[2:0] == SRC_CH1 && counter_compare_output_i[1] |=>
            unit_drive_o.fine_on)
        else $error("Fine gate stayed off while enabled");

    AST_GATE_CH0: assert property ( // [R7]
        cfg_q[CFG_EN_BIT] && cfg_q[2:0] == SRC_CH0 |=>
            unit_drive_o.fine_on == $past(counter_compare_output_i[0]))
        else $error("Fine gate does not track channel 0");

    AST_GATE_CH2: assert property ( // [R7]
        cfg_q[CFG_EN_BIT] && cfg_q[2:0] == SRC_CH2 |=>
            unit_drive_o.fine_on == $past(counter_compare_output_i[2]))
        else $error("Fine gate does not track channel 2");

    AST_GATE_ADDS_TWO: assert property ( // [R8]
        cfg_q[CFG_EN_BIT] && cfg_q[2:0] == SRC_CH0 && counter_compare_output_i[0] |=>
            unit_drive_o.total_steps == {1'b0, $past(ctrl_q[5:0])} + 7'h02)
        else $error("Open gate did not add two steps");

    AST_TOTAL_LIMIT: assert property ( // [R8]
        unit_drive_o.total_steps <= 7'h41)
        else $error("Total steps above full scale plus two");

    AST_FULL_DUTY_SAME_OUTPUT: assert property ( // [R9]
        unit_drive_o.fine_on && unit_drive_o.step_count[1:0] == 2'b00 |->
            unit_drive_o.total_steps == {1'b0, unit_drive_o.step_count[5:2], 2'b10})
        else $error("Full duty differs from setting 10b");

    AST_RESERVED_TOTAL: assert property ( // [R13]
        cfg_q[2:0] > SRC_CH2 |=>
            unit_drive_o.total_steps == {1'b0, unit_drive_o.step_count})
        else $error("Reserved source code added current");

    // Code 4 aliases channel 0 in the low index bits, the likeliest leak
    AST_RESERVED_ALIAS_LOW: assert property ( // [R13]
        cfg_q[CFG_EN_BIT] && cfg_q[2:0] == 3'h4 && counter_compare_output_i[0] |=>
            !unit_drive_o.fine_on)
        else $error("Reserved code aliased channel 0");

    // ==========================================================
    // Register port
    // ==========================================================
    AST_CTRL_WRITE_LANDS: assert property ( // [R5]
        sfr_wr_i && ctrl_hit |=> ctrl_q == $past(sfr_wdata_i))
        else $error("Control write did not land");

    AST_CTRL_HOLD: assert property ( // [R5]
        !(sfr_wr_i && ctrl_hit) |=> $stable(ctrl_q))
        else $error("Control register changed without a write");

    AST_CTRL_READBACK: assert property ( // [R5]
        sfr_rd_i && ctrl_hit |=> sfr_rdata_o == $past(ctrl_q))
        else $error("Control read returned wrong value");

    AST_UNMAPPED_READ_ZERO: assert property ( // [R5]
        sfr_rd_i && !ctrl_hit && !cfg_hit |=> sfr_rdata_o == 8'h00)
        else $error("Unmapped read returned nonzero");

    AST_CFG_UNUSED_NEVER_STORED: assert property ( // [R10]
        cfg_q[6:3] == 4'h0)
        else $error("Config unused bits were stored");

    AST_CFG_HOLD: assert property ( // [R11]
        !(sfr_wr_i && cfg_hit) |=> $stable(cfg_q))
        else $error("Config register changed without a write");

    AST_CFG_READBACK: assert property ( // [R11]
        sfr_rd_i && cfg_hit |=> sfr_rdata_o == $past(cfg_q))
        else $error("Config read returned wrong value");

    AST_CFG_WRITE_SPARES_CTRL: assert property ( // [R5]
        sfr_wr_i && cfg_hit |=> $stable(ctrl_q))
        else $error("Config write disturbed control register");

    AST_RESET_RDATA: assert property ( // [R12]
        @(posedge ref_clk_i) disable iff (1'b0)
        srst_i |=> sfr_rdata_o == 8'h00)
        else $error("Read data not zero after reset");

    COV_SINK_HIGH: cover property (unit_drive_o.enable && unit_drive_o.sink &&
                                   unit_drive_o.high_range);
    COV_FINE_GATE: cover property (unit_drive_o.fine_on ##1 !unit_drive_o.fine_on);
    COV_CFG_READ:  cover property (sfr_rd_i && cfg_hit ##1 sfr_rdata_o[7]);
    COV_DISABLE:   cover property (unit_drive_o.enable ##[1:20] !unit_drive_o.enable);
    COV_RESERVED:  cover property (cfg_q[CFG_EN_BIT] && cfg_q[2:0] > SRC_CH2);

endmodule

// File: current_ref_control_tb_top.sv
/* Self-checking bench: register port accesses, compare gating, pin current.
   Assumes single-cycle strobes driven just after the rising edge. */
`timescale 1ns/1ps
module current_ref_control_tb_top;
    import current_ref_pkg::*;
    logic        clk, srst, wr, rd;
    logic [7:0]  addr, wdata, rdata;
    logic [3:0]  page;
    logic [2:0]  cmp;
    unit_drive_t drive;
    int          cur, n_errors, cmp_count, ch;
    current_ref_control u_current_ref_control (.ref_clk_i(clk), .srst_i(srst),
        .sfr_addr_i(addr), .sfr_page_i(page), .sfr_wr_i(wr), .sfr_rd_i(rd),
        .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .counter_compare_output_i(cmp),
        .unit_drive_o(drive));
    current_pin_model u_current_pin_model (.drive_i(drive), .current_ua_o(cur));
    // ==========================================
    // Helpers
    // ==========================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One access; waits until read data and drive word have settled
    task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] p,
                       input logic [7:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        page <= p;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic gate(input logic [2:0] v);
        @(posedge clk);
        cmp <= v;
        repeat (2) @(posedge clk);
        #1;
    endtask
    function automatic unit_drive_t xd(input logic [7:0] c, input logic f);
        xd = {|c[5:0], c[7], c[6], c[5:0], f, 7'(c[5:0]) + (f ? FINE_WEIGHT : 7'h00)};
    endfunction
    task automatic final_report;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    // ==========================================
    task automatic t_regs;
        chk(drive, '0);
        acc(0, CFG_ADDR, 4'h3, 0);
        chk(rdata, CFG_RESET);
        acc(1, CTRL_ADDR, CTRL_PAGE, 8'h45);
        chk(drive, xd(8'h45, 0));
        chk(cur, 40);
        acc(1, CTRL_ADDR, CTRL_PAGE, 8'hc1);
        chk(cur, -8);
        acc(1, CTRL_ADDR, CTRL_PAGE, 8'h3f);
        chk(cur, 63);
        acc(1, CTRL_ADDR, CTRL_PAGE, 8'h80);
        chk(drive, xd(8'h80, 0));
        acc(1, CTRL_ADDR, 4'h1, 8'h7f);
        chk(drive, xd(8'h80, 0));
        acc(0, CTRL_ADDR, 4'h1, 0);
        chk(rdata, UNMAPPED_READ);
        acc(0, CTRL_ADDR, CTRL_PAGE, 0);
        chk(rdata, 8'h80);
        acc(1, CFG_ADDR, 4'hf, 8'h7a);
        acc(0, CFG_ADDR, 4'h0, 0);
        chk(rdata, 8'h02);
    endtask
    task automatic t_fine;
        acc(1, CTRL_ADDR, CTRL_PAGE, 8'h04);
        for (ch = 0; ch < 3; ch++) begin
            acc(1, CFG_ADDR, 4'h0, {5'b10000, 3'(ch)});
            gate(3'b111 ^ 3'(1 << ch));
            chk(drive, xd(8'h04, 0));
            gate(3'(1 << ch));
            chk(drive, xd(8'h04, 1));
            chk(drive.total_steps, xd(8'h06, 0).total_steps);
            acc(1, CFG_ADDR, 4'h0, {5'b00000, 3'(ch)});
            chk(drive, xd(8'h04, 0));
        end
        gate(3'b111);
        for (ch = 3; ch < 8; ch++) begin
            acc(1, CFG_ADDR, 4'h0, {5'b10000, 3'(ch)});
            chk(drive, xd(8'h04, 0));
        end
    endtask
    // Reset in mid-run, with both registers and the compare inputs away from zero
    task automatic t_reset;
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        chk(drive, '0);
        acc(0, CTRL_ADDR, CTRL_PAGE, 0);
        chk(rdata, CTRL_RESET);
        acc(0, CFG_ADDR, 4'h0, 0);
        chk(rdata, CFG_RESET);
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Hang guard: no scenario needs this many cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        final_report();
    end
    initial begin
        {srst, wr, rd, addr, page, wdata, cmp} = {1'b1, 25'h0};
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        t_regs();
        t_fine();
        t_reset();
        final_report();
    end
endmodule

// File: current_ref_pkg.sv
/*
 * Shared constants and carrier types for the programmable current unit
 * control logic: register addresses, field positions, reset values and
 * the decoded output bundle.
 * Assumes a byte-wide special-function register port with a page number.
 */
package current_ref_pkg;

    // ==========================================================
    // Register addresses and pages
    // ==========================================================
    localparam logic [7:0] CTRL_ADDR        = 8'hd6;
    localparam logic [3:0] CTRL_PAGE        = 4'h0;
    localparam logic [7:0] CFG_ADDR         = 8'hb9;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int         CTRL_SINK_BIT    = 7;
    localparam int         CTRL_RANGE_BIT   = 6;
    localparam int         CTRL_STEP_MSB    = 5;
    localparam int         CFG_EN_BIT       = 7;
    localparam int         CFG_SRC_MSB      = 2;

    // ==========================================================
    // Reset values and codes
    // ==========================================================
    localparam logic [7:0] CTRL_RESET       = 8'h00;
    localparam logic [7:0] CFG_RESET        = 8'h00;
    localparam logic [7:0] CFG_WRITE_MASK   = 8'h87;
    localparam logic [7:0] UNMAPPED_READ    = 8'h00;
    localparam logic [5:0] STEP_OFF         = 6'h00;
    localparam logic [6:0] FINE_WEIGHT      = 7'h02;
    localparam logic [2:0] SRC_CH0          = 3'h0;
    localparam logic [2:0] SRC_CH1          = 3'h1;
    localparam logic [2:0] SRC_CH2          = 3'h2;

    // Step sizes in microamps, for reference by software models
    localparam int         STEP_LOW_UA      = 1;
    localparam int         STEP_HIGH_UA     = 8;

    typedef struct packed {
        logic       enable;
        logic       sink;
        logic       high_range;
        logic [5:0] step_count;
        logic       fine_on;
        logic [6:0] total_steps;
    } unit_drive_t;

endpackage
